// ### rtl/wdsup_top.sv
// Watchdog supervisor: kick timeout driving an active-low fault output
// How it works
// - Any level change on the kick input counts as a valid service event.
// - With no kick for the whole timeout, the fault output is driven low.
// - Once low, the fault output stays low until the next kick transition.
// - The watchdog only runs while the enable strap is asserted.
module wdsup_top
    import wdsup_pkg::*;
#(
    parameter longint TIMEOUT_CYC = WDSUP_TIMEOUT_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_watchdog_kick_input,
    input wire logic i_watchdog_enable_strap,
    output logic o_watchdog_fault_output,
    output logic o_watchdog_running
);
    localparam logic [WDSUP_CNT_W-1:0] LAST_CNT =
        WDSUP_CNT_W'(TIMEOUT_CYC - 1);

    wdsup_state_t state;
    wdsup_state_t next_state;
    logic [WDSUP_CNT_W-1:0] count;
    logic kick;
    logic expire;

    // Last count of a period; the counter parks here rather than wrap
    function automatic logic wdsup_at_limit(
        input logic [WDSUP_CNT_W-1:0] value
    );
        logic hit;
        hit = 1'h0;
        if (value == LAST_CNT) begin
            hit = 1'h1;
        end
        return hit;
    endfunction : wdsup_at_limit

    // One step of the period counter, saturating at the last count
    function automatic logic [WDSUP_CNT_W-1:0] wdsup_count_step(
        input logic [WDSUP_CNT_W-1:0] value
    );
        logic [WDSUP_CNT_W-1:0] result;
        result = value;
        if (!wdsup_at_limit(value)) begin
            result = value + 1'b1;
        end
        return result;
    endfunction : wdsup_count_step

    // Landing state after a kick or a strap change
    function automatic wdsup_state_t wdsup_resume(
        input logic strap
    );
        wdsup_state_t landing;
        case (strap)
            1'h1: begin
                landing = WDSUP_RUN;
            end
            default: begin
                landing = WDSUP_OFF;
            end
        endcase
        return landing;
    endfunction : wdsup_resume

    // Leaving RUN: strap removal first, then expiry
    function automatic wdsup_state_t wdsup_from_run(
        input logic strap,
        input logic due
    );
        wdsup_state_t landing;
        landing = WDSUP_RUN;
        // Strap removal outranks expiry, so a disabled timer never trips
        if (!strap) begin
            landing = WDSUP_OFF;
        end else if (due) begin
            landing = WDSUP_TRIP;
        end
        return landing;
    endfunction : wdsup_from_run

    // Leaving TRIP: only a kick releases, whatever the strap does
    function automatic wdsup_state_t wdsup_from_trip(
        input logic strap,
        input logic toggled
    );
        wdsup_state_t landing;
        landing = WDSUP_TRIP;
        // Strap removal does not clear a trip; only a kick does
        if (toggled) begin
            landing = wdsup_resume(strap);
        end
        return landing;
    endfunction : wdsup_from_trip

    // A period restarts on a kick and whenever the timer is not in RUN,
    // the entry cycle included, so every period is counted from zero
    function automatic logic wdsup_count_clear(
        input wdsup_state_t now,
        input wdsup_state_t upcoming,
        input logic toggled
    );
        logic clear;
        clear = 1'h0;
        if (toggled) begin
            clear = 1'h1;
        end else if (now != WDSUP_RUN) begin
            clear = 1'h1;
        end else if (upcoming != WDSUP_RUN) begin
            clear = 1'h1;
        end
        return clear;
    endfunction : wdsup_count_clear

    // Fault pin level for a state; only a trip pulls it low
    function automatic logic wdsup_fault_level(
        input wdsup_state_t st
    );
        logic level;
        level = WDSUP_FAULT_IDLE;
        case (st)
            WDSUP_TRIP: begin
                level = WDSUP_FAULT_LOW;
            end
            default: begin
                level = WDSUP_FAULT_IDLE;
            end
        endcase
        return level;
    endfunction : wdsup_fault_level

    // Status level for a state; high only while a period is being timed
    // It is a status only and plays no part in the trip decision
    function automatic logic wdsup_running_level(
        input wdsup_state_t st
    );
        logic level;
        level = 1'h0;
        case (st)
            WDSUP_RUN: begin
                level = 1'h1;
            end
            default: begin
                level = 1'h0;
            end
        endcase
        return level;
    endfunction : wdsup_running_level

    // Kick detector arms on its first sample after reset
    wdsup_edge u_edge (
        .i_core_clk(i_core_clk),
        .i_rst_b(i_rst_b),
        .i_level(i_watchdog_kick_input),
        .o_toggle(kick)
    );

    // Host keeps kick spacing under the timeout; we only measure it
    // A kick in the expiry cycle wins, so a late but present kick never trips
    always_comb begin
        expire = wdsup_at_limit(count) && !kick;
    end

    always_comb begin
        next_state = state;
        case (state)
            WDSUP_OFF: begin
                next_state = wdsup_resume(i_watchdog_enable_strap);
            end
            WDSUP_RUN: begin
                next_state = wdsup_from_run(i_watchdog_enable_strap, expire);
            end
            WDSUP_TRIP: begin
                next_state = wdsup_from_trip(i_watchdog_enable_strap, kick);
            end
            default: begin
                next_state = WDSUP_OFF;
            end
        endcase
    end

    // State advances on every edge; reset parks it in OFF
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= WDSUP_OFF;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            count <= '0;
        end else if (wdsup_count_clear(state, next_state, kick)) begin
            count <= '0;
        end else begin
            count <= wdsup_count_step(count);
        end
    end

    // Registered from next_state so a releasing kick shows at its own edge
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_watchdog_fault_output <= WDSUP_FAULT_IDLE;
        end else begin
            o_watchdog_fault_output <=
                wdsup_fault_level(next_state);
        end
    end

    // Status follows the upcoming state, like the fault pin
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_watchdog_running <= 1'h0;
        end else begin
            o_watchdog_running <= wdsup_running_level(next_state);
        end
    end
endmodule : wdsup_top

// ### rtl/wdsup_pkg.sv
// Package with timing constants for the watchdog supervisor
package wdsup_pkg;
    // Core clock rate in Hz
    localparam longint WDSUP_CLK_HZ = 40000000;
    // Kick timeout in milliseconds
    localparam longint WDSUP_TIMEOUT_MS = 1600;
    // Longest time, so the cycle count rounds down
    localparam longint WDSUP_TIMEOUT_CYC =
        (WDSUP_CLK_HZ * WDSUP_TIMEOUT_MS) / 1000;
    localparam int WDSUP_CNT_W = 27;
    localparam logic WDSUP_FAULT_IDLE = 1'h1;
    localparam logic WDSUP_FAULT_LOW = 1'h0;

    typedef enum logic [1:0] {
        WDSUP_OFF,
        WDSUP_RUN,
        WDSUP_TRIP
    } wdsup_state_t;
endpackage : wdsup_pkg

// ### rtl/wdsup_edge.sv
// Kick transition detector
module wdsup_edge
    import wdsup_pkg::*;
(
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_level,
    output logic o_toggle
);
    logic armed;
    logic last;

    // First sample after reset only arms, so a high idle line is no kick
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            last <= 1'h0;
            armed <= 1'h0;
        end else begin
            last <= i_level;
            armed <= 1'h1;
        end
    end

    // Either direction of the level counts as a kick
    always_comb begin
        o_toggle = armed && (i_level != last);
    end
endmodule : wdsup_edge

// ### bench/wdsup_host.sv
// Host model that toggles the kick line on request
module wdsup_host (
    input wire logic i_core_clk,
    input wire logic i_go,
    output logic o_kick = 1'h0
);
    always @(posedge i_core_clk) if (i_go) o_kick <= ~o_kick;
endmodule : wdsup_host

// ### bench/wdsup_props.sv
// Port checker for the watchdog supervisor
module wdsup_props #(parameter longint TIMEOUT_CYC = 8) (
    input wire logic i_core_clk,
    input wire logic i_rst_b,
    input wire logic i_watchdog_kick_input,
    input wire logic i_watchdog_enable_strap,
    input wire logic o_watchdog_fault_output,
    input wire logic o_watchdog_running
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rst_b);
    wire k = i_watchdog_kick_input;
    wire s = i_watchdog_enable_strap;
    wire f = o_watchdog_fault_output;
    wire r = o_watchdog_running;
    // Window of 8 matches the short timeout the bench binds in
    trip_due_a: assert property ((r && s && $stable(k))[*8] |=> !f)
        else $error("no trip");
    kick_release_a: assert property (!f && $changed(k) |=> f)
        else $error("no release");
    hold_low_a: assert property (!f && $stable(k) |=> !f)
        else $error("early release");
    full_period_a: assert property ($changed(k) && s |=> f[*8])
        else $error("early trip");
    strap_off_a: assert property (!s |=> !r) else $error("runs");
    cover property ($fell(f));
    cover property ($rose(f));
    cover property (!s ##1 !s);
endmodule : wdsup_props
bind wdsup_top wdsup_props #(.TIMEOUT_CYC(TIMEOUT_CYC)) chk (.*);

// ### bench/wdsup_top_tb_top.sv
// Self-checking bench for the watchdog supervisor
module wdsup_top_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_core_clk = 1'h0, i_rst_b = 1'h0, go = 1'h0;
    logic i_watchdog_enable_strap = 1'h0, i_watchdog_kick_input;
    logic o_watchdog_fault_output, o_watchdog_running;
    int failures = 0, checks = 0;
    always #12.5 i_core_clk = ~i_core_clk;
    wdsup_host host (.i_core_clk, .i_go(go), .o_kick(i_watchdog_kick_input));
    wdsup_top #(.TIMEOUT_CYC(8)) uut (.*);
    task automatic step(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask : step
    task automatic check(input logic e, input logic a);
        checks++;
        if (a !== e) begin
            failures++;
            $display("MISMATCH %0t %h %h", $time, e, a);
        end
    endtask : check
    task automatic kick();
        go = 1'h1;
        step(1);
        go = 1'h0;
    endtask : kick
    task automatic trip_run();
        kick();
        step(8);
        check(1'h1, o_watchdog_fault_output);
        step(1);
        check(1'h0, o_watchdog_fault_output);
    endtask : trip_run
    task automatic hold_run();
        i_watchdog_enable_strap = 1'h0;
        step(5);
        check(1'h0, o_watchdog_fault_output);
        kick();
        step(1);
        check(1'h1, o_watchdog_fault_output);
        step(20);
        check(1'h0, o_watchdog_running);
    endtask : hold_run
    task automatic complete_run();
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        step(10);
        i_rst_b = 1'h1;
        i_watchdog_enable_strap = 1'h1;
        step(2);
        trip_run();
        hold_run();
        complete_run();
    end
endmodule : wdsup_top_tb_top
